// *** src/asect_ctrl.sv ***
module asect_ctrl #(
	parameter int unsigned POWER_WAIT_CYCLES = asect_pkg::FIRST_ACCESS_WAIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [asect_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asect_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	output logic rsp_valid,
	output logic [asect_pkg::DATA_W-1:0] rsp_rdata,
	output logic init_done,
	output logic [asect_pkg::ADDR_W-1:0] sram_addr,
	output logic chip_select_n,
	output logic output_drive_n,
	output logic write_strobe_n,
	output logic upper_lane_n,
	output logic lower_lane_n,
	output logic [asect_pkg::DATA_W-1:0] sram_data_out,
	output logic sram_data_oe,
	input wire logic [asect_pkg::DATA_W-1:0] sram_data_in
);
	import asect_pkg::*;

	typedef struct packed {
		asect_state_e state;
		logic [ADDR_W-1:0] addr;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic upper_n;
		logic lower_n;
		logic [DATA_W-1:0] dout;
		logic doe;
		logic [DATA_W-1:0] lane_mask;
		logic ready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic init;
	} asect_ctrl_s;

	localparam asect_ctrl_s CTRL_RESET = '{
		state: ST_BOOT,
		addr: ADDR_RESET,
		cs_n: 1'b1,
		oe_n: 1'b1,
		we_n: 1'b1,
		upper_n: 1'b1,
		lower_n: 1'b1,
		dout: DATA_RESET,
		doe: 1'b0,
		lane_mask: DATA_RESET,
		ready: 1'b0,
		rvalid: 1'b0,
		rdata: DATA_RESET,
		init: 1'b0
	};

	asect_ctrl_s s_reg;
	asect_ctrl_s s_next;
	logic timer_load;
	logic [TIMER_W-1:0] timer_value;
	logic timer_done;
	logic [DATA_W-1:0] data_sync;
	logic [DATA_W-1:0] req_mask;
	logic [DATA_W-1:0] rd_masked;
	logic req_take;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	asect_timer u_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.load(timer_load),
		.load_value(timer_value),
		.done(timer_done)
	);

	asect_sync u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(sram_data_in),
		.sync_out(data_sync)
	);

	// ----------------------------------------
	// Lane decode
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign req_mask[g*(DATA_W/2) +: DATA_W/2] = {(DATA_W/2){req_lanes[g]}};
		assign rd_masked[g*(DATA_W/2) +: DATA_W/2] = data_sync[g*(DATA_W/2) +: DATA_W/2] & s_reg.lane_mask[g*(DATA_W/2) +: DATA_W/2];
	end

	assign req_take = req_valid && s_reg.ready;

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		timer_load = 1'b0;
		timer_value = '0;
		unique case (s_reg.state)
			ST_BOOT: begin
				s_next.state = ST_POWER;
			end
			ST_POWER: begin
				if (timer_done) begin
					s_next.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (req_take) begin
					s_next.addr = req_addr;
					s_next.lane_mask = req_mask;
					if (req_write) begin
						s_next.dout = req_wdata;
						s_next.state = ST_WR_SETUP;
					end else begin
						s_next.state = ST_RD_ACCESS;
					end
				end
			end
			ST_RD_ACCESS: begin
				if (timer_done) begin
					s_next.rdata = rd_masked;
					s_next.state = ST_RD_FLOAT;
				end
			end
			ST_RD_FLOAT: begin
				if (timer_done) begin
					s_next.state = ST_IDLE;
				end
			end
			ST_WR_SETUP: begin
				s_next.state = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				if (timer_done) begin
					s_next.state = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				s_next.state = ST_IDLE;
			end
		endcase

		// ----------------------------------------
		// Timer loads on state entry
		// ----------------------------------------
		if (s_next.state != s_reg.state) begin
			unique case (s_next.state)
				ST_BOOT: begin
					timer_load = 1'b0;
					timer_value = '0;
				end
				ST_POWER: begin
					timer_load = 1'b1;
					timer_value = TIMER_W'(POWER_WAIT_CYCLES);
				end
				ST_IDLE: begin
					timer_load = 1'b0;
					timer_value = '0;
				end
				ST_RD_ACCESS: begin
					timer_load = 1'b1;
					timer_value = TIMER_W'(READ_WAIT_CYCLES);
				end
				ST_RD_FLOAT: begin
					timer_load = 1'b1;
					timer_value = TIMER_W'(FLOAT_WAIT_CYCLES);
				end
				ST_WR_SETUP: begin
					timer_load = 1'b0;
					timer_value = '0;
				end
				ST_WR_PULSE: begin
					timer_load = 1'b1;
					timer_value = TIMER_W'(WRITE_PULSE_CYCLES);
				end
				ST_WR_HOLD: begin
					timer_load = 1'b0;
					timer_value = '0;
				end
			endcase
		end

		// ----------------------------------------
		// Pin picture of the next state
		// ----------------------------------------
		unique case (s_next.state)
			ST_BOOT: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b0;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
			ST_POWER: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b0;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
			ST_IDLE: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b0;
				s_next.ready = 1'b1;
				s_next.rvalid = 1'b0;
				s_next.init = 1'b1;
			end
			ST_RD_ACCESS: begin
				s_next.cs_n = 1'b0;
				s_next.oe_n = 1'b0;
				s_next.we_n = 1'b1;
				s_next.upper_n = ~s_next.lane_mask[DATA_W-1];
				s_next.lower_n = ~s_next.lane_mask[0];
				s_next.doe = 1'b0;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
			ST_RD_FLOAT: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b0;
				s_next.ready = 1'b0;
				s_next.rvalid = (s_reg.state == ST_RD_ACCESS);
				s_next.init = s_reg.init;
			end
			ST_WR_SETUP: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b0;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
			ST_WR_PULSE: begin
				s_next.cs_n = 1'b0;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b0;
				s_next.upper_n = ~s_next.lane_mask[DATA_W-1];
				s_next.lower_n = ~s_next.lane_mask[0];
				s_next.doe = 1'b1;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
			ST_WR_HOLD: begin
				s_next.cs_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.we_n = 1'b1;
				s_next.upper_n = 1'b1;
				s_next.lower_n = 1'b1;
				s_next.doe = 1'b1;
				s_next.ready = 1'b0;
				s_next.rvalid = 1'b0;
				s_next.init = s_reg.init;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign req_ready = s_reg.ready;
	assign rsp_valid = s_reg.rvalid;
	assign rsp_rdata = s_reg.rdata;
	assign init_done = s_reg.init;
	assign sram_addr = s_reg.addr;
	assign chip_select_n = s_reg.cs_n;
	assign output_drive_n = s_reg.oe_n;
	assign write_strobe_n = s_reg.we_n;
	assign upper_lane_n = s_reg.upper_n;
	assign lower_lane_n = s_reg.lower_n;
	assign sram_data_out = s_reg.dout;
	assign sram_data_oe = s_reg.doe;
endmodule

// *** pkg/asect_pkg.sv ***
// Notes on behaviour
// - Write needs strobe, select, a lane low
// - Time data against the terminating rising edge
// - Strobe-only write with drive low: long strobe
// - Never drive data while device drives
// - Wait 100 us before first access
// - Address stable 7 ns before write end
// - Address valid when write begins
// - Write data valid 5 ns before end
// - Write data held after write end
// - Lane enable low 7 ns before end
// - Write strobe high throughout reads
// - Read address valid by select fall
// - Lanes pick low, high or both bytes
package asect_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int TIMER_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h0_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] LOWER_MASK = 16'h00ff;
	localparam logic [DATA_W-1:0] UPPER_MASK = 16'hff00;

	// ----------------------------------------
	// Timing figures
	// ----------------------------------------
	localparam real CLK_PERIOD_NS = 5.0;
	localparam real FIRST_ACCESS_WAIT_US = 100.0;
	localparam real ADDR_TO_DATA_NS = 10.0;
	localparam real LANE_TO_FLOAT_NS = 6.0;
	localparam real WRITE_PULSE_NS = 7.0;
	localparam real STROBE_TO_FLOAT_DELAY_NS = 5.0;
	localparam real WRITE_DATA_SETUP_NS = 5.0;
	localparam int SYNC_CYCLES = 4;

	function automatic int ceil_cycles(input real t_ns);
		int n;
		n = int'($ceil(t_ns / CLK_PERIOD_NS));
		return (n < 1) ? 1 : n;
	endfunction

	function automatic int max_int(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam int FIRST_ACCESS_WAIT_CYCLES = ceil_cycles(FIRST_ACCESS_WAIT_US * 1000.0);
	localparam int READ_WAIT_CYCLES = ceil_cycles(ADDR_TO_DATA_NS) + SYNC_CYCLES;
	localparam int FLOAT_WAIT_CYCLES = ceil_cycles(LANE_TO_FLOAT_NS);
	localparam int WRITE_PULSE_CYCLES = max_int(ceil_cycles(WRITE_PULSE_NS),
		ceil_cycles(STROBE_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS));

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_POWER,
		ST_IDLE,
		ST_RD_ACCESS,
		ST_RD_FLOAT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD
	} asect_state_e;

endpackage

// *** src/asect_sync.sv ***
module asect_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [asect_pkg::DATA_W-1:0] async_in,
	output logic [asect_pkg::DATA_W-1:0] sync_out
);
	import asect_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] ff1;
		logic [DATA_W-1:0] ff2;
		logic [DATA_W-1:0] ff3;
		logic [DATA_W-1:0] held;
	} asect_sync_s;

	asect_sync_s s_reg;
	asect_sync_s s_next;
	logic [DATA_W-1:0] held_next;

	// ----------------------------------------
	// Accept a change once stages two and three agree
	// ----------------------------------------
	for (genvar i = 0; i < DATA_W; i++) begin : g_bit
		assign held_next[i] = (s_reg.ff2[i] == s_reg.ff3[i]) ? s_reg.ff3[i] : s_reg.held[i];
	end

	always_comb begin
		s_next = s_reg;
		s_next.ff1 = async_in;
		s_next.ff2 = s_reg.ff1;
		s_next.ff3 = s_reg.ff2;
		s_next.held = held_next;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.held;
endmodule

// *** src/asect_timer.sv ***
module asect_timer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [asect_pkg::TIMER_W-1:0] load_value,
	output logic done
);
	import asect_pkg::*;

	typedef struct packed {
		logic [TIMER_W-1:0] count;
	} asect_timer_s;

	asect_timer_s s_reg;
	asect_timer_s s_next;

	// ----------------------------------------
	// Down counter, done at zero
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		if (load) begin
			s_next.count = load_value;
		end else if (s_reg.count != '0) begin
			s_next.count = s_reg.count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done = (s_reg.count == '0);
endmodule

// *** verif/asect_assertions.sv ***
module asect_assertions #(
	parameter int unsigned POWER_WAIT_CYCLES = asect_pkg::FIRST_ACCESS_WAIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic rsp_valid,
	input wire logic init_done,
	input wire logic [asect_pkg::ADDR_W-1:0] sram_addr,
	input wire logic chip_select_n,
	input wire logic output_drive_n,
	input wire logic write_strobe_n,
	input wire logic upper_lane_n,
	input wire logic lower_lane_n,
	input wire logic [asect_pkg::DATA_W-1:0] sram_data_out,
	input wire logic sram_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import asect_pkg::*;
	int unsigned cnt_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			cnt_reg <= 0;
		else if (!init_done)
			cnt_reg <= cnt_reg + 1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_rd_we; !output_drive_n |-> write_strobe_n; endproperty
	a_rd_we: assert property (p_rd_we) else $error("strobe in read");
	property p_clash; sram_data_oe |-> output_drive_n; endproperty
	a_clash: assert property (p_clash) else $error("bus clash");
	property p_wdata; !write_strobe_n |-> sram_data_oe && $stable(sram_data_out); endproperty
	a_wdata: assert property (p_wdata) else $error("data setup");
	property p_whold; $rose(write_strobe_n) |-> sram_data_oe && $stable(sram_data_out); endproperty
	a_whold: assert property (p_whold) else $error("data hold");
	property p_wpulse; $fell(write_strobe_n) |-> (!write_strobe_n && !chip_select_n)[*3]
		##1 (write_strobe_n && chip_select_n && upper_lane_n && lower_lane_n); endproperty
	a_wpulse: assert property (p_wpulse) else $error("pulse");
	property p_addr; !chip_select_n && !$fell(chip_select_n) |-> $stable(sram_addr); endproperty
	a_addr: assert property (p_addr) else $error("addr moved");
	property p_rdtime; $fell(output_drive_n) |-> (!output_drive_n && !chip_select_n)[*7]
		##1 (rsp_valid && output_drive_n); endproperty
	a_rdtime: assert property (p_rdtime) else $error("read time");
	property p_wait; !init_done |-> chip_select_n; endproperty
	a_wait: assert property (p_wait) else $error("early access");
	property p_waitn; $rose(init_done) |-> cnt_reg >= POWER_WAIT_CYCLES; endproperty
	a_waitn: assert property (p_waitn) else $error("short wait");
endmodule

bind asect_ctrl asect_assertions #(.POWER_WAIT_CYCLES(POWER_WAIT_CYCLES)) i_chk (.*);

// *** verif/asect_sram_model.sv ***
module asect_sram_model (
	input wire logic sys_clk,
	input wire logic chip_select_n,
	input wire logic output_drive_n,
	input wire logic write_strobe_n,
	input wire logic upper_lane_n,
	input wire logic lower_lane_n,
	input wire logic [asect_pkg::ADDR_W-1:0] sram_addr,
	input wire logic [asect_pkg::DATA_W-1:0] sram_data_out,
	input wire logic sram_data_oe,
	output logic [asect_pkg::DATA_W-1:0] sram_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import asect_pkg::*;
	logic [DATA_W-1:0] mem [0:15];
	logic [DATA_W-1:0] last = 16'h0000;
	logic [DATA_W-1:0] dev;
	logic rd;
	logic wr;
	assign wr = !chip_select_n && !write_strobe_n && !(upper_lane_n && lower_lane_n);
	assign rd = !chip_select_n && !output_drive_n && write_strobe_n;
	assign dev[7:0] = (rd && !lower_lane_n) ? mem[sram_addr[3:0]][7:0] : ~last[7:0];
	assign dev[15:8] = (rd && !upper_lane_n) ? mem[sram_addr[3:0]][15:8] : ~last[15:8];
	assign #3 sram_data_in = sram_data_oe ? sram_data_out : dev;
	always @(posedge sys_clk) begin
		last <= sram_data_in;
		if (wr && !lower_lane_n)
			mem[sram_addr[3:0]][7:0] <= sram_data_in[7:0];
		if (wr && !upper_lane_n)
			mem[sram_addr[3:0]][15:8] <= sram_data_in[15:8];
	end
endmodule

// *** verif/asect_ctrl_tb.sv ***
module asect_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asect_pkg::*;
	localparam int unsigned P = 10;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = 20'h0_0000;
	logic [DATA_W-1:0] req_wdata = 16'h0000;
	logic [1:0] req_lanes = 2'h0;
	logic req_ready, rsp_valid, init_done, chip_select_n, output_drive_n;
	logic write_strobe_n, upper_lane_n, lower_lane_n, sram_data_oe;
	logic [DATA_W-1:0] rsp_rdata, sram_data_out, sram_data_in;
	logic [ADDR_W-1:0] sram_addr;
	int bad_count = 0;
	int checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	asect_ctrl #(.POWER_WAIT_CYCLES(P)) i_dut (.*);
	asect_sram_model i_mem (.*);
	task test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	task req(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
		int n;
		n = 0;
		@(posedge sys_clk);
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_lanes <= l;
		req_valid <= 1'b1;
		#1;
		while (req_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 500) begin
				chk(1'b0, "ready timeout");
				test_done;
			end
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask
	task rd(input logic [19:0] a, input logic [1:0] l, input logic [15:0] e);
		int n;
		req(1'b0, a, 16'h0000, l);
		n = 0;
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(n == READ_WAIT_CYCLES + 1, "read latency");
		if (n >= 20)
			test_done;
		chk(rsp_rdata === e, "read data");
	endtask
	task s_power;
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(n >= P && n < 100 && req_ready === 1'b1, "power wait");
		if (n >= 100)
			test_done;
	endtask
	task s_full;
		req(1'b1, 20'h0_0005, 16'ha5c3, 2'h3);
		rd(20'h0_0005, 2'h3, 16'ha5c3);
		rd(20'h0_0005, 2'h1, 16'h00c3);
		rd(20'h0_0005, 2'h2, 16'ha500);
		rd(20'h0_0005, 2'h0, 16'h0000);
	endtask
	task s_bytes;
		req(1'b1, 20'h0_0005, 16'h1e2f, 2'h1);
		rd(20'h0_0005, 2'h3, 16'ha52f);
		req(1'b1, 20'h0_0005, 16'h3b4a, 2'h2);
		rd(20'h0_0005, 2'h3, 16'h3b2f);
		req(1'b1, 20'h0_0005, 16'hffff, 2'h0);
		rd(20'h0_0005, 2'h3, 16'h3b2f);
	endtask
	task s_b2b;
		req(1'b1, 20'h0_0009, 16'h7788, 2'h3);
		req(1'b1, 20'h0_000a, 16'h99aa, 2'h3);
		rd(20'h0_0009, 2'h3, 16'h7788);
		rd(20'h0_000a, 2'h3, 16'h99aa);
	endtask
	task s_reset;
		req(1'b1, 20'h0_0003, 16'h5a5a, 2'h3);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		#1;
		chk(write_strobe_n === 1'b1 && sram_data_oe === 1'b0, "abort pins");
		@(posedge sys_clk);
		reset_n <= 1'b1;
		s_power;
		rd(20'h0_0009, 2'h3, 16'h7788);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		chk(chip_select_n === 1'b1 && req_ready === 1'b0, "reset pins");
		reset_n <= 1'b1;
		s_power;
		s_full;
		s_bytes;
		s_b2b;
		s_reset;
		test_done;
	end
endmodule
